/* sac_defs.svh */
// timing and code constants for the single-address cycle sequencer
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH
`define SAC_EXC_NONE 3'h7
`define SAC_EXC_HALT 3'h6
`define SAC_EXC_BERR 3'h5
`define SAC_EXC_RETRY 3'h4
`define SAC_EXC_RELQ 3'h3
`define SAC_EXC_RESET 3'h0
`define SAC_RD_EXC_WAITS 2'h2
`define SAC_WR_EXC_WAITS 2'h1
`define SAC_FIFO_DEPTH 4
`define SAC_FC_W 3
`define SAC_ADDR_W 23
`endif

/* sac_pkg.sv */
// types shared by the single-address cycle sequencer
package sac_pkg;
  typedef struct packed {
    logic [2:0] fc;   // function code for memory
    logic [22:0] addr; // word address (A23..A1)
    logic rd;          // 1: memory to device
    logic byte_port;   // 8-bit device port
    logic byte_xfer;   // single byte transfer
    logic odd;         // byte address odd
    logic ready_proto; // acknowledge-with-ready protocol
    logic last;        // last transfer of the block
  } cycle_req_t;

  typedef enum logic [2:0] {
    EXC_NONE, EXC_HALT, EXC_BERR, EXC_RETRY, EXC_RELQ, EXC_RSVD, EXC_RESET
  } exc_kind_t;

  typedef struct packed {
    logic normal;          // completed with acknowledge
    exc_kind_t exc;        // exception that ended it
  } cycle_result_t;
endpackage : sac_pkg

/* sac_fifo.sv */
// small valid/ready FIFO for queued cycle requests
`timescale 1ns/1ps
module sac_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic ref_clk, // controller clock
  input wire logic sys_rst, // sync reset, high
  input wire logic [WIDTH-1:0] in_data, // write data
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  output logic [WIDTH-1:0] out_data, // head word
  output logic out_valid, // head valid
  input wire logic out_ready // consumer takes head
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (cnt_r != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];

  // storage; no reset needed on data
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sac_fifo

/* sac_seq.sv */
// single-address DMA bus-cycle sequencer, top level
// What this block does
// - read S0: drive function code and address, upper strobe on, read/write high
// - data buffer enable held inactive high throughout every single-address cycle
// - read S2: upper strobe off, address and data strobes on, ack, done if last
// - read of 8-bit port at even address: lane swap on, upper data strobe only
// - read S3: float address/data, sample ack and exception; ack goes to S4
// - read exception by S3: two wait cycles before S4
// - read with no termination: wait until one appears, then S4
// - ready protocol read: leave S3 only when terminated and device ready low
// - read S4/S5: outputs unchanged while inputs synchronise
// - transfer complete only on normal termination, never on exception codes
// - read S8, write S9: address and data strobes negated; memory may then release inputs
// - after cycle: next address if another follows, else float the lines
// - end: negate ack, complete, done, lane swap; device may drop ready
// - ready write: sample ready at end of S1; low skips SD0 and SD1
// - write S2: upper strobe off, address strobe on, read/write low
// - write S3: float address/data, assert ack, done if last
// - write from 8-bit port at even address: lane swap on, upper strobe only
// - ack-only write: S4 follows S3 directly
// - ready write: ready low at S3 gives SD0/SD1; high adds wait pairs
// - write with ack by S3: skip S6/S7, go S5 to S8
// - write exception by S3: one wait cycle between S5 and S6
// - write with no termination: run S6 and S7, waiting as needed
// - exception code decode: all high none, all low reset, two reserved
// - write S5: data strobes assert, device data valid for memory
`timescale 1ns/1ps
`include "sac_defs.svh"
module sac_seq (
  input wire logic ref_clk, // 40 MHz controller clock
  input wire logic sys_rst, // sync reset, high
  input wire sac_pkg::cycle_req_t req_data, // queued cycle request
  input wire logic req_valid, // request offered
  output logic req_ready, // queue has space
  output sac_pkg::cycle_result_t res_data, // result of finished cycle
  output logic res_valid, // one-cycle result pulse
  input wire logic transfer_ack_in_n, // memory acknowledge pin, low active
  input wire logic [2:0] bus_exception_code_n, // exception code pins
  input wire logic peripheral_ready_line, // device ready, low = ready
  output logic [2:0] function_code_lines, // function code out
  output logic function_code_lines_oe_n, // low while driven
  output logic [22:0] addr_out, // address out (A23..A1)
  output logic addr_out_oe_n, // low while driven
  output logic upper_addr_strobe_n, // upper address strobe
  output logic addr_strobe_n, // address strobe
  output logic upper_data_strobe_n, // upper data strobe
  output logic lower_data_strobe_n, // lower data strobe
  output logic rd_wr, // high = read
  output logic data_buffer_enable_n, // external buffers, kept high
  output logic dev_ack_n, // device acknowledge
  output logic done_n, // last transfer marker
  output logic transfer_complete_out_n, // normal termination to device
  output logic byte_lane_swap_n // lane swap buffer control
);
  // ****************************************************
  // request queue
  // ****************************************************
  sac_pkg::cycle_req_t q_data;
  logic q_valid, q_take;

  sac_fifo #(.WIDTH($bits(sac_pkg::cycle_req_t)), .DEPTH(`SAC_FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_data(req_data),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(q_take)
  );

  // ****************************************************
  // input synchronisers and exception decode
  // ****************************************************
  logic ack_m_r, ack_s_r, rdy_m_r, rdy_s_r;
  logic [2:0] exc_m_r, exc_s_r, exc_d_r;
  logic exc_stable;
  sac_pkg::exc_kind_t exc_kind;

  function automatic sac_pkg::exc_kind_t decode_exc(input logic [2:0] c);
    unique case (c)
      `SAC_EXC_NONE: decode_exc = sac_pkg::EXC_NONE;
      `SAC_EXC_HALT: decode_exc = sac_pkg::EXC_HALT;
      `SAC_EXC_BERR: decode_exc = sac_pkg::EXC_BERR;
      `SAC_EXC_RETRY: decode_exc = sac_pkg::EXC_RETRY;
      `SAC_EXC_RELQ: decode_exc = sac_pkg::EXC_RELQ;
      `SAC_EXC_RESET: decode_exc = sac_pkg::EXC_RESET;
      default: decode_exc = sac_pkg::EXC_RSVD;
    endcase
  endfunction : decode_exc

  // two flops per pin, one more stage on the exception code for debounce
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ack_m_r <= 1'b1;
      ack_s_r <= 1'b1;
      rdy_m_r <= 1'b1;
      rdy_s_r <= 1'b1;
      exc_m_r <= `SAC_EXC_NONE;
      exc_s_r <= `SAC_EXC_NONE;
      exc_d_r <= `SAC_EXC_NONE;
    end else begin
      ack_m_r <= transfer_ack_in_n;
      ack_s_r <= ack_m_r;
      rdy_m_r <= peripheral_ready_line;
      rdy_s_r <= rdy_m_r;
      exc_m_r <= bus_exception_code_n;
      exc_s_r <= exc_m_r;
      exc_d_r <= exc_s_r;
    end
  end

  // an encoding counts only when two successive samples agree
  assign exc_stable = (exc_s_r == exc_d_r);
  assign exc_kind = exc_stable ? decode_exc(exc_s_r) : sac_pkg::EXC_NONE;

  logic ack_seen, exc_seen, rdy_seen;
  assign ack_seen = !ack_s_r;
  // halt and reserved codes are not cycle terminators here
  assign exc_seen = (exc_kind == sac_pkg::EXC_BERR) || (exc_kind == sac_pkg::EXC_RETRY) ||
                    (exc_kind == sac_pkg::EXC_RELQ) || (exc_kind == sac_pkg::EXC_RESET);
  assign rdy_seen = !rdy_s_r;

  // ****************************************************
  // cycle state machine
  // ****************************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_S0, ST_S1, ST_S2, ST_S3, ST_SW, ST_SD0, ST_SD1,
    ST_S4, ST_S5, ST_EXW, ST_S6, ST_S7, ST_S8, ST_S9
  } state_t;

  state_t state_r, state_nxt;
  sac_pkg::cycle_req_t cur_r;
  logic term_r, normal_r, skip_sd_r;
  logic [1:0] wcnt_r;
  logic sw_half_r;
  sac_pkg::exc_kind_t exc_r;
  logic term_now;

  // termination also needs the device's ready under the ready protocol in a read
  assign term_now = (ack_seen || exc_seen) && (!cur_r.rd || !cur_r.ready_proto || rdy_seen);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: state_nxt = q_valid ? ST_S0 : ST_IDLE;
      ST_S0: state_nxt = ST_S1;
      ST_S1: state_nxt = ST_S2;
      ST_S2: state_nxt = ST_S3;
      ST_S3: begin
        if (cur_r.rd) begin
          if (term_now) begin
            state_nxt = (exc_seen && !ack_seen) ? ST_EXW : ST_S4;
          end else begin
            state_nxt = ST_S3;
          end
        end else if (!cur_r.ready_proto || skip_sd_r) begin
          state_nxt = ST_S4;
        end else begin
          state_nxt = rdy_seen ? ST_SD0 : ST_SW;
        end
      end
      ST_SW: state_nxt = (sw_half_r && rdy_seen) ? ST_SD0 : ST_SW;
      ST_SD0: state_nxt = ST_SD1;
      ST_SD1: state_nxt = ST_S4;
      ST_EXW: state_nxt = (wcnt_r == 2'h1) ? (cur_r.rd ? ST_S4 : ST_S6) : ST_EXW;
      ST_S4: state_nxt = ST_S5;
      ST_S5: begin
        if (cur_r.rd) begin
          state_nxt = ST_S6;
        end else if (term_r && normal_r) begin
          state_nxt = ST_S8;
        end else if (term_r) begin
          state_nxt = ST_EXW;
        end else if (ack_seen) begin
          state_nxt = ST_S6;
        end else if (exc_seen) begin
          state_nxt = ST_EXW;
        end else begin
          state_nxt = ST_S5;
        end
      end
      ST_S6: state_nxt = cur_r.rd ? ST_S7 : ST_S7;
      ST_S7: state_nxt = cur_r.rd ? ST_S8 : ST_S8;
      ST_S8: state_nxt = ST_S9;
      ST_S9: state_nxt = q_valid ? ST_S0 : ST_IDLE;
    endcase
  end

  // for the read the sequence after S5 is S6 (complete), S7, S8 (strobes off), S9 (end)
  assign q_take = ((state_r == ST_IDLE) || (state_r == ST_S9)) && q_valid;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // current request latched as the next cycle begins
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cur_r <= '0;
    end else if (q_take) begin
      cur_r <= q_data;
    end
  end

  // termination capture: first termination seen from S3 on is remembered
  always_ff @(posedge ref_clk) begin
    if (sys_rst || q_take) begin
      term_r <= 1'b0;
      normal_r <= 1'b0;
      exc_r <= sac_pkg::EXC_NONE;
    end else if (!term_r && (state_r == ST_S3 || state_r == ST_SW || state_r == ST_SD0 ||
                 state_r == ST_SD1 || state_r == ST_S4 || state_r == ST_S5) && (ack_seen || exc_seen)) begin
      term_r <= 1'b1;
      normal_r <= ack_seen && !exc_seen;
      exc_r <= exc_kind;
    end
  end

  // ready sampled at the edge ending S1
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      skip_sd_r <= 1'b0;
    end else if (state_r == ST_S1) begin
      skip_sd_r <= rdy_seen;
    end
  end

  // wait counters: exception waits and two-state ready-wait pairs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wcnt_r <= 2'h0;
      sw_half_r <= 1'b0;
    end else begin
      if (state_nxt == ST_EXW && state_r != ST_EXW) begin
        wcnt_r <= cur_r.rd ? `SAC_RD_EXC_WAITS : `SAC_WR_EXC_WAITS;
      end else if (state_r == ST_EXW) begin
        wcnt_r <= wcnt_r - 2'h1;
      end
      sw_half_r <= (state_r == ST_SW) ? !sw_half_r : 1'b0;
    end
  end

  // ****************************************************
  // bus outputs, all registered, from the next state or the current one
  // ****************************************************
  logic swap_case;
  assign swap_case = cur_r.byte_port && !cur_r.odd;

  // address phase; lines float when no cycle follows
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      function_code_lines <= 3'h0;
      addr_out <= 23'h000000;
      function_code_lines_oe_n <= 1'b1;
      addr_out_oe_n <= 1'b1;
    end else if (q_take) begin
      function_code_lines <= q_data.fc;
      addr_out <= q_data.addr;
      function_code_lines_oe_n <= 1'b0;
      addr_out_oe_n <= 1'b0;
    end else if (state_nxt == ST_S3) begin
      addr_out_oe_n <= 1'b1;
    end else if (state_nxt == ST_IDLE) begin
      function_code_lines_oe_n <= 1'b1;
    end
  end

  // strobes and direction
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      upper_addr_strobe_n <= 1'b1;
      addr_strobe_n <= 1'b1;
      upper_data_strobe_n <= 1'b1;
      lower_data_strobe_n <= 1'b1;
      rd_wr <= 1'b1;
    end else begin
      if (q_take) begin
        upper_addr_strobe_n <= 1'b0;
        rd_wr <= 1'b1;
      end else if (state_nxt == ST_S2) begin
        upper_addr_strobe_n <= 1'b1;
        addr_strobe_n <= 1'b0;
        rd_wr <= cur_r.rd;
      end else if (state_nxt == ST_S9 || (cur_r.rd && state_nxt == ST_S8)) begin
        addr_strobe_n <= 1'b1;
        upper_data_strobe_n <= 1'b1;
        lower_data_strobe_n <= 1'b1;
      end else if (state_nxt == ST_IDLE) begin
        rd_wr <= 1'b1;
      end
      // data strobes: read at S2, write at S5; even 8-bit port uses upper only
      if ((cur_r.rd && state_nxt == ST_S2 && state_r == ST_S1) ||
          (!cur_r.rd && state_nxt == ST_S5 && state_r == ST_S4)) begin
        upper_data_strobe_n <= !(swap_case || !cur_r.byte_xfer || !cur_r.odd);
        lower_data_strobe_n <= !(!swap_case && (!cur_r.byte_xfer || cur_r.odd));
      end
    end
  end

  // device handshake outputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dev_ack_n <= 1'b1;
      done_n <= 1'b1;
      byte_lane_swap_n <= 1'b1;
      transfer_complete_out_n <= 1'b1;
      data_buffer_enable_n <= 1'b1;
    end else begin
      data_buffer_enable_n <= 1'b1;
      if ((cur_r.rd && state_nxt == ST_S2 && state_r == ST_S1) ||
          (!cur_r.rd && state_nxt == ST_S3 && state_r == ST_S2)) begin
        dev_ack_n <= 1'b0;
        done_n <= !cur_r.last;
        byte_lane_swap_n <= !swap_case;
      end else if (state_r == ST_S9 || state_r == ST_IDLE) begin
        dev_ack_n <= 1'b1;
        done_n <= 1'b1;
        byte_lane_swap_n <= 1'b1;
        transfer_complete_out_n <= 1'b1;
      end
      // read: S4/S5 hold everything, complete at S6; write: complete at S8
      if ((cur_r.rd && state_nxt == ST_S6 && state_r == ST_S5) ||
          (!cur_r.rd && state_nxt == ST_S8 && state_r != ST_S8)) begin
        transfer_complete_out_n <= !normal_r;
      end
    end
  end

  // result pulse at cycle end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      res_valid <= 1'b0;
      res_data <= '0;
    end else begin
      res_valid <= (state_r == ST_S8);
      if (state_r == ST_S8) begin
        res_data.normal <= normal_r;
        res_data.exc <= exc_r;
      end
    end
  end
endmodule : sac_seq

/* sac_seq_assertions.sv */
// pin-level checks on the single-address cycle sequencer
`timescale 1ns/1ps
module sac_seq_chk (
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // reset
  input wire sac_pkg::cycle_result_t res_data, // result
  input wire logic res_valid, // result pulse
  input wire logic function_code_lines_oe_n, // fc float
  input wire logic addr_out_oe_n, // address float
  input wire logic upper_addr_strobe_n, // upper strobe
  input wire logic addr_strobe_n, // address strobe
  input wire logic upper_data_strobe_n, // upper lane
  input wire logic lower_data_strobe_n, // lower lane
  input wire logic rd_wr, // direction
  input wire logic data_buffer_enable_n, // buffers
  input wire logic dev_ack_n, // device ack
  input wire logic done_n, // last marker
  input wire logic transfer_complete_out_n, // complete
  input wire logic byte_lane_swap_n // lane swap
);
  // ****************************************
  // cycle sequencing checks
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic seen_r;
  // completion memory; cleared at cycle start so an exception cycle cannot inherit it
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !upper_addr_strobe_n) seen_r <= 1'b0;
    else if (!transfer_complete_out_n) seen_r <= 1'b1;
  end
  buf_off_a: assert property (data_buffer_enable_n) else $error("buffer enable low");
  s0_drive_a: assert property ($fell(upper_addr_strobe_n) |->
    rd_wr && !function_code_lines_oe_n && !addr_out_oe_n) else $error("start lines wrong");
  s2_order_a: assert property ($fell(addr_strobe_n) |-> $rose(upper_addr_strobe_n))
    else $error("strobe handover wrong");
  rd_s2_a: assert property ($fell(addr_strobe_n) && rd_wr |->
    !dev_ack_n && !(upper_data_strobe_n && lower_data_strobe_n)) else $error("read s2 wrong");
  rd_float_a: assert property ($fell(addr_strobe_n) && rd_wr |-> ##[0:2] addr_out_oe_n)
    else $error("read address not floated");
  wr_s3_a: assert property ($fell(addr_strobe_n) && !rd_wr |->
    upper_data_strobe_n && lower_data_strobe_n ##[1:2] !dev_ack_n) else $error("write s3 wrong");
  lane_a: assert property (!byte_lane_swap_n |-> lower_data_strobe_n)
    else $error("lane swap with lower strobe");
  done_ack_a: assert property (!done_n |-> !dev_ack_n) else $error("done without ack");
  ds_off_a: assert property ($rose(addr_strobe_n) |-> upper_data_strobe_n && lower_data_strobe_n)
    else $error("data strobes outlive address strobe");
  end_hs_a: assert property ($rose(addr_strobe_n) |-> ##[0:3]
    (dev_ack_n && done_n && transfer_complete_out_n && byte_lane_swap_n)) else $error("handshake held");
  lines_a: assert property ($rose(addr_strobe_n) |-> ##[0:4]
    (function_code_lines_oe_n || !upper_addr_strobe_n)) else $error("lines left driven");
  cmpl_a: assert property (res_valid |-> res_data.normal == (seen_r || !transfer_complete_out_n))
    else $error("complete disagrees with result");
  rd_c: cover property ($fell(addr_strobe_n) && rd_wr);
  wr_c: cover property ($fell(addr_strobe_n) && !rd_wr);
  exc_c: cover property (res_valid && !res_data.normal);
endmodule : sac_seq_chk
bind sac_seq sac_seq_chk chk_u (.ref_clk, .sys_rst, .res_data, .res_valid, .function_code_lines_oe_n,
  .addr_out_oe_n, .upper_addr_strobe_n, .addr_strobe_n, .upper_data_strobe_n, .lower_data_strobe_n,
  .rd_wr, .data_buffer_enable_n, .dev_ack_n, .done_n, .transfer_complete_out_n, .byte_lane_swap_n);

/* sac_bus_model.sv */
// far-side model: memory answer and device ready
`timescale 1ns/1ps
`include "sac_defs.svh"
module sac_bus_model (
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // reset
  input wire logic addr_strobe_n, // memory cycle on
  input wire logic upper_addr_strobe_n, // cycle start
  input wire logic dev_ack_n, // device ack
  input wire logic [7:0] ack_dly, // strobe to answer
  input wire logic [2:0] exc_cfg, // answer code
  input wire logic [7:0] rdy_dly, // start to ready
  output logic transfer_ack_in_n, // memory ack
  output logic [2:0] bus_exception_code_n, // exception code
  output logic peripheral_ready_line // low = ready
);
  // ****************************************
  // far-side behaviour
  // ****************************************
  logic [7:0] ack_cnt_r;
  logic [7:0] rdy_cnt_r;
  // memory answers late and lets go once the strobe rises; pull-ups idle the lines high
  always_ff @(posedge ref_clk) begin
    if (sys_rst || addr_strobe_n) begin
      ack_cnt_r <= 8'h00;
      transfer_ack_in_n <= 1'b1;
      bus_exception_code_n <= `SAC_EXC_NONE;
    end else if (ack_cnt_r == ack_dly) begin
      transfer_ack_in_n <= exc_cfg != `SAC_EXC_NONE;
      bus_exception_code_n <= exc_cfg;
    end else ack_cnt_r <= ack_cnt_r + 8'h01;
  end
  // device ready holds low until upper strobe, address strobe and device ack are all back high
  always_ff @(posedge ref_clk) begin
    if (sys_rst || (upper_addr_strobe_n && addr_strobe_n && dev_ack_n)) begin
      rdy_cnt_r <= 8'h00;
      peripheral_ready_line <= 1'b1;
    end else if (rdy_cnt_r == rdy_dly) peripheral_ready_line <= 1'b0;
    else rdy_cnt_r <= rdy_cnt_r + 8'h01;
  end
endmodule : sac_bus_model

/* testbench.sv */
// self-checking bench for the single-address cycle sequencer
`timescale 1ns/1ps
`include "sac_defs.svh"
module testbench;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  logic refused = 1'b0;
  sac_pkg::cycle_req_t req_data = '0;
  sac_pkg::cycle_result_t res_data;
  logic req_ready, res_valid, transfer_ack_in_n, peripheral_ready_line, function_code_lines_oe_n;
  logic addr_out_oe_n, upper_addr_strobe_n, addr_strobe_n, upper_data_strobe_n, lower_data_strobe_n;
  logic rd_wr, data_buffer_enable_n, dev_ack_n, done_n, transfer_complete_out_n, byte_lane_swap_n;
  logic [2:0] bus_exception_code_n, function_code_lines;
  logic [22:0] addr_out;
  logic [7:0] ack_dly = 8'h02;
  logic [7:0] rdy_dly = 8'h00;
  logic [2:0] exc_cfg = `SAC_EXC_NONE;
  logic [6:0] saw_r = '0; // sticky low levels seen in this cycle
  logic [25:0] s0_r = '0; // fc and address at cycle start
  int as_cnt = 0;
  int res_cnt = 0;
  int cyc_cnt = 0;
  int error_cnt = 0;
  int samples_checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  sac_seq dut_u (.ref_clk, .sys_rst, .req_data, .req_valid, .req_ready, .res_data, .res_valid,
    .transfer_ack_in_n, .bus_exception_code_n, .peripheral_ready_line, .function_code_lines,
    .function_code_lines_oe_n, .addr_out, .addr_out_oe_n, .upper_addr_strobe_n, .addr_strobe_n,
    .upper_data_strobe_n, .lower_data_strobe_n, .rd_wr, .data_buffer_enable_n, .dev_ack_n, .done_n,
    .transfer_complete_out_n, .byte_lane_swap_n);
  sac_bus_model mdl_u (.ref_clk, .sys_rst, .addr_strobe_n, .upper_addr_strobe_n, .dev_ack_n, .ack_dly,
    .exc_cfg, .rdy_dly, .transfer_ack_in_n, .bus_exception_code_n, .peripheral_ready_line);
  // ****************************************
  // monitor and compare tasks
  // ****************************************
  // sampled between edges so every output has settled
  always @(negedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (!addr_strobe_n) as_cnt <= as_cnt + 1;
    if (!upper_addr_strobe_n) s0_r <= {function_code_lines, addr_out};
    if (res_valid === 1'b1) res_cnt <= res_cnt + 1;
    saw_r <= saw_r | {!(upper_data_strobe_n && lower_data_strobe_n) && peripheral_ready_line && !rd_wr,
      !transfer_complete_out_n, !rd_wr, !done_n, !lower_data_strobe_n, !upper_data_strobe_n, !byte_lane_swap_n};
    if (cyc_cnt == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic check(input string name, input logic [25:0] exp, input logic [25:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic check_res(input sac_pkg::cycle_result_t exp, input sac_pkg::cycle_result_t got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch result expected %h seen %h", exp, got);
    end
  endtask : check_res
  // holds valid until an edge that sees ready; hold keeps it up for the next request
  task automatic push(input sac_pkg::cycle_req_t rq, input logic hold);
    req_data <= rq;
    req_valid <= 1'b1;
    @(negedge ref_clk);
    while (req_ready !== 1'b1) begin
      refused = 1'b1;
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    if (!hold) req_valid <= 1'b0;
  endtask : push
  task automatic run(input sac_pkg::cycle_req_t rq, input logic [2:0] code, input sac_pkg::exc_kind_t ek);
    sac_pkg::cycle_result_t exp;
    int n;
    exp.normal = ek == sac_pkg::EXC_NONE;
    exp.exc = ek;
    n = 0;
    repeat (4) @(posedge ref_clk);
    saw_r = '0;
    as_cnt = 0;
    exc_cfg <= code;
    push(rq, 1'b0);
    while (res_valid !== 1'b1 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    check_res(exp, res_data);
    @(posedge ref_clk);
  endtask : run
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_read;
    run({3'h5, 23'h2A5A5A, 6'b111001}, `SAC_EXC_NONE, sac_pkg::EXC_NONE);
    check("start", {3'h5, 23'h2A5A5A}, s0_r);
    check("flags", 7'h2B, saw_r);
    rdy_dly <= 8'h14;
    run({3'h1, 23'h000101, 6'b111110}, `SAC_EXC_NONE, sac_pkg::EXC_NONE);
    check("flags", 7'h24, saw_r);
    check("ready wait", 1'b1, as_cnt >= 18);
    ack_dly <= 8'h1E;
    run({3'h1, 23'h000102, 6'b100000}, `SAC_EXC_NONE, sac_pkg::EXC_NONE);
    check("ack wait", 1'b1, as_cnt >= 30);
  endtask : t_read
  task automatic t_exc;
    logic [2:0] codes [4] = '{`SAC_EXC_BERR, `SAC_EXC_RETRY, `SAC_EXC_RELQ, `SAC_EXC_RESET};
    sac_pkg::exc_kind_t kinds [4] = '{sac_pkg::EXC_BERR, sac_pkg::EXC_RETRY, sac_pkg::EXC_RELQ, sac_pkg::EXC_RESET};
    ack_dly <= 8'h01;
    for (int i = 0; i < 8; i++) begin
      run({3'h2, 23'h0004F0, i[0], 5'h00}, codes[i/2], kinds[i/2]);
      check("complete", 1'b0, saw_r[5]);
    end
  endtask : t_exc
  task automatic t_write;
    int n;
    rdy_dly <= 8'h00;
    ack_dly <= 8'h02;
    run({3'h3, 23'h3C0010, 6'b011001}, `SAC_EXC_NONE, sac_pkg::EXC_NONE);
    check("flags", 7'h3B, saw_r);
    ack_dly <= 8'h04;
    run({3'h3, 23'h3C0011, 6'b000010}, `SAC_EXC_NONE, sac_pkg::EXC_NONE);
    check("early", 1'b0, saw_r[6]);
    n = as_cnt;
    rdy_dly <= 8'h10;
    ack_dly <= 8'h14;
    run({3'h3, 23'h3C0012, 6'b000010}, `SAC_EXC_NONE, sac_pkg::EXC_NONE);
    check("strobe before ready", 1'b0, saw_r[6]);
    check("strobe seen", 1'b1, saw_r[1]);
    check("delay states", 1'b1, as_cnt > n);
  endtask : t_write
  task automatic t_fill;
    int n;
    n = 0;
    ack_dly <= 8'h0A;
    exc_cfg <= `SAC_EXC_NONE;
    repeat (4) @(posedge ref_clk);
    res_cnt = 0;
    for (int i = 0; i < 6; i++) push({3'h4, 23'h001000 + i[22:0], 6'b100000}, i < 5);
    check("queue refused", 1'b1, refused);
    while (res_cnt < 6 && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    check("drained", 6, res_cnt);
    check("next addr", {3'h4, 23'h001005}, s0_r);
  endtask : t_fill
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // reset, idle levels, then each scenario in turn
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    check("idle", 3'h7, {addr_strobe_n, function_code_lines_oe_n, data_buffer_enable_n});
    t_read();
    t_exc();
    t_write();
    t_fill();
    end_of_test();
  end
endmodule : testbench
